/* crf_pkg.sv */
// ****************************************
// Core register file package
// ****************************************
package crf_pkg;

  // Bank geometry
  localparam int NUM_BANKS = 2;
  localparam int NUM_REGS = 7;
  localparam int REG_W = 16;
  localparam int LONG_W = 32;

  // Word index of each register inside a bank
  localparam logic [2:0] IDX_D0 = 3'h0;
  localparam logic [2:0] IDX_D1 = 3'h1;
  localparam logic [2:0] IDX_D2 = 3'h2;
  localparam logic [2:0] IDX_D3 = 3'h3;
  localparam logic [2:0] IDX_ADR0 = 3'h4;
  localparam logic [2:0] IDX_ADR1 = 3'h5;
  localparam logic [2:0] IDX_FRM = 3'h6;

  // Value of every register after reset
  localparam logic [15:0] REG_RESET = 16'h0000;

  // Bus map, byte addresses
  localparam int AXI_AW = 8;
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_STATUS = 8'h04;
  localparam logic [7:0] OFS_FILE_BASE = 8'h40;
  localparam logic [7:0] OFS_FILE_END = 8'h80;
  localparam int FILE_BANK_BIT = 5;
  localparam int FILE_IDX_LSB = 2;
  localparam int CTRL_BANK_BIT = 0;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // Operand selector used by the execution logic
  typedef enum logic [3:0] {
    CRF_SEL_D0 = 4'h0,
    CRF_SEL_D1 = 4'h1,
    CRF_SEL_D2 = 4'h2,
    CRF_SEL_D3 = 4'h3,
    CRF_SEL_ADR0 = 4'h4,
    CRF_SEL_ADR1 = 4'h5,
    CRF_SEL_FRM = 4'h6,
    CRF_SEL_D0_HI = 4'h7,
    CRF_SEL_D0_LO = 4'h8,
    CRF_SEL_D1_HI = 4'h9,
    CRF_SEL_D1_LO = 4'ha,
    CRF_SEL_PAIR_LOW_LONG = 4'hb,
    CRF_SEL_PAIR_HIGH_LONG = 4'hc,
    CRF_SEL_ADDR_PAIR_LONG = 4'hd
  } crf_sel_e;

  typedef logic [NUM_REGS-1:0][REG_W-1:0] crf_bank_t;
  typedef logic [NUM_BANKS-1:0][NUM_REGS-1:0][REG_W-1:0] crf_file_t;

  // Core read request
  typedef struct packed {
    logic en;
    crf_sel_e sel;
  } crf_rd_req_s;

  // Core write request
  typedef struct packed {
    logic en;
    crf_sel_e sel;
    logic [LONG_W-1:0] data;
  } crf_wr_req_s;

endpackage : crf_pkg

/* crf_core_regfile.sv */
// Operation
// - The core holds the data, address and frame base registers, counted once per bank copy.
// - Data registers zero to three, address registers zero and one and the frame base form one bank.
// - There are two bank copies, each keeping its own independent values.
// - Each data register is 16 bits and can be read and written as a whole word.
// - Data registers zero and one also split into a high and a low byte, each readable and writable.
// - Registers two and zero pair into a 32-bit long with two on top, and three and one likewise.
// - Each address register is a 16-bit word readable and writable as an operand.
// - Address registers one and zero pair into a 32-bit address with one on top.
//
// Chosen here: the AXI4-Lite register port and the address map.
`timescale 1ns/1ps
`default_nettype none

module crf_core_regfile #(
  parameter int ADDR_W = crf_pkg::AXI_AW
) (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Core read port
  input wire crf_pkg::crf_rd_req_s rd_req,
  output logic [31:0] rd_data,
  output logic rd_valid,
  // Core write port
  input wire crf_pkg::crf_wr_req_s wr_req,
  // Bank currently in use
  output logic bank_sel,
  // AXI4-Lite write address and data
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  // AXI4-Lite write response
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // AXI4-Lite read
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready
);

  // ****************************************
  // Parameter check
  // ****************************************
  if (ADDR_W < crf_pkg::AXI_AW) begin : g_bad_addr_w
    $error("ADDR_W too narrow for the register map");
  end

  // ****************************************
  // State
  // ****************************************
  typedef struct packed {
    crf_pkg::crf_file_t file;
    logic bank;
    logic [31:0] rd_data;
    logic rd_valid;
    logic aw_have;
    logic [7:0] aw_addr;
    logic w_have;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } crf_state_s;

  crf_state_s s_r;
  crf_state_s s_nxt;

  // ****************************************
  // Functions
  // ****************************************

  // Operand read from one bank
  function automatic logic [31:0] read_op(crf_pkg::crf_bank_t b, crf_pkg::crf_sel_e sel);
    logic [31:0] v;
    v = 32'h0000_0000;
    unique case (sel)
      crf_pkg::CRF_SEL_D0: v = {16'h0000, b[crf_pkg::IDX_D0]};
      crf_pkg::CRF_SEL_D1: v = {16'h0000, b[crf_pkg::IDX_D1]};
      crf_pkg::CRF_SEL_D2: v = {16'h0000, b[crf_pkg::IDX_D2]};
      crf_pkg::CRF_SEL_D3: v = {16'h0000, b[crf_pkg::IDX_D3]};
      crf_pkg::CRF_SEL_ADR0: v = {16'h0000, b[crf_pkg::IDX_ADR0]};
      crf_pkg::CRF_SEL_ADR1: v = {16'h0000, b[crf_pkg::IDX_ADR1]};
      crf_pkg::CRF_SEL_FRM: v = {16'h0000, b[crf_pkg::IDX_FRM]};
      crf_pkg::CRF_SEL_D0_HI: v = {24'h00_0000, b[crf_pkg::IDX_D0][15:8]};
      crf_pkg::CRF_SEL_D0_LO: v = {24'h00_0000, b[crf_pkg::IDX_D0][7:0]};
      crf_pkg::CRF_SEL_D1_HI: v = {24'h00_0000, b[crf_pkg::IDX_D1][15:8]};
      crf_pkg::CRF_SEL_D1_LO: v = {24'h00_0000, b[crf_pkg::IDX_D1][7:0]};
      crf_pkg::CRF_SEL_PAIR_LOW_LONG: v = {b[crf_pkg::IDX_D2], b[crf_pkg::IDX_D0]};
      crf_pkg::CRF_SEL_PAIR_HIGH_LONG: v = {b[crf_pkg::IDX_D3], b[crf_pkg::IDX_D1]};
      crf_pkg::CRF_SEL_ADDR_PAIR_LONG: v = {b[crf_pkg::IDX_ADR1], b[crf_pkg::IDX_ADR0]};
      default: v = 32'h0000_0000;
    endcase
    return v;
  endfunction : read_op

  // Operand write into one bank
  function automatic crf_pkg::crf_bank_t write_op(crf_pkg::crf_bank_t b,
                                                  crf_pkg::crf_sel_e sel, logic [31:0] d);
    crf_pkg::crf_bank_t v;
    v = b;
    unique case (sel)
      crf_pkg::CRF_SEL_D0: v[crf_pkg::IDX_D0] = d[15:0];
      crf_pkg::CRF_SEL_D1: v[crf_pkg::IDX_D1] = d[15:0];
      crf_pkg::CRF_SEL_D2: v[crf_pkg::IDX_D2] = d[15:0];
      crf_pkg::CRF_SEL_D3: v[crf_pkg::IDX_D3] = d[15:0];
      crf_pkg::CRF_SEL_ADR0: v[crf_pkg::IDX_ADR0] = d[15:0];
      crf_pkg::CRF_SEL_ADR1: v[crf_pkg::IDX_ADR1] = d[15:0];
      crf_pkg::CRF_SEL_FRM: v[crf_pkg::IDX_FRM] = d[15:0];
      crf_pkg::CRF_SEL_D0_HI: v[crf_pkg::IDX_D0][15:8] = d[7:0];
      crf_pkg::CRF_SEL_D0_LO: v[crf_pkg::IDX_D0][7:0] = d[7:0];
      crf_pkg::CRF_SEL_D1_HI: v[crf_pkg::IDX_D1][15:8] = d[7:0];
      crf_pkg::CRF_SEL_D1_LO: v[crf_pkg::IDX_D1][7:0] = d[7:0];
      crf_pkg::CRF_SEL_PAIR_LOW_LONG: begin
        v[crf_pkg::IDX_D2] = d[31:16];
        v[crf_pkg::IDX_D0] = d[15:0];
      end
      crf_pkg::CRF_SEL_PAIR_HIGH_LONG: begin
        v[crf_pkg::IDX_D3] = d[31:16];
        v[crf_pkg::IDX_D1] = d[15:0];
      end
      crf_pkg::CRF_SEL_ADDR_PAIR_LONG: begin
        v[crf_pkg::IDX_ADR1] = d[31:16];
        v[crf_pkg::IDX_ADR0] = d[15:0];
      end
      default: v = b;
    endcase
    return v;
  endfunction : write_op

  // True when an address falls on a stored register word
  function automatic logic in_file(logic [7:0] a);
    return (a >= crf_pkg::OFS_FILE_BASE) && (a < crf_pkg::OFS_FILE_END) &&
           (a[4:crf_pkg::FILE_IDX_LSB] != 3'h7) && (a[1:0] == 2'h0);
  endfunction : in_file

  // ****************************************
  // Next state
  // ****************************************
  always_comb begin
    logic [7:0] ra;
    logic wb;
    logic [2:0] wi;
    logic [15:0] old;
    ra = 8'h00;
    wb = 1'b0;
    wi = 3'h0;
    old = 16'h0000;
    s_nxt = s_r;

    // Core operand read, one cycle later, current bank
    s_nxt.rd_valid = rd_req.en;
    if (rd_req.en) begin
      s_nxt.rd_data = read_op(s_r.file[s_r.bank], rd_req.sel);
    end

    // Accept address and data in either order
    if (s_axi_awvalid && s_r.awready) begin
      s_nxt.aw_have = 1'b1;
      s_nxt.aw_addr = s_axi_awaddr[7:0];
    end
    if (s_axi_wvalid && s_r.wready) begin
      s_nxt.w_have = 1'b1;
      s_nxt.w_data = s_axi_wdata;
      s_nxt.w_strb = s_axi_wstrb;
    end

    // Retire write response
    if (s_r.bvalid && s_axi_bready) begin
      s_nxt.bvalid = 1'b0;
    end

    // Perform bus write once both halves are held
    if (s_r.aw_have && s_r.w_have && !s_r.bvalid) begin
      s_nxt.aw_have = 1'b0;
      s_nxt.w_have = 1'b0;
      s_nxt.bvalid = 1'b1;
      s_nxt.bresp = crf_pkg::RESP_OKAY;
      wb = s_r.aw_addr[crf_pkg::FILE_BANK_BIT];
      wi = s_r.aw_addr[4:crf_pkg::FILE_IDX_LSB];
      if (s_r.aw_addr == crf_pkg::OFS_CTRL) begin
        if (s_r.w_strb[0]) begin
          s_nxt.bank = s_r.w_data[crf_pkg::CTRL_BANK_BIT];
        end
      end else if (in_file(s_r.aw_addr)) begin
        old = s_r.file[wb][wi];
        if (s_r.w_strb[0]) begin
          old[7:0] = s_r.w_data[7:0];
        end
        if (s_r.w_strb[1]) begin
          old[15:8] = s_r.w_data[15:8];
        end
        s_nxt.file[wb][wi] = old;
      end else if (s_r.aw_addr != crf_pkg::OFS_STATUS) begin
        s_nxt.bresp = crf_pkg::RESP_SLVERR;
      end
    end

    // Bus read
    if (s_r.rvalid && s_axi_rready) begin
      s_nxt.rvalid = 1'b0;
    end
    if (s_axi_arvalid && s_r.arready) begin
      ra = s_axi_araddr[7:0];
      s_nxt.rvalid = 1'b1;
      s_nxt.rresp = crf_pkg::RESP_OKAY;
      s_nxt.rdata = 32'h0000_0000;
      if ((ra == crf_pkg::OFS_CTRL) || (ra == crf_pkg::OFS_STATUS)) begin
        s_nxt.rdata[crf_pkg::CTRL_BANK_BIT] = s_r.bank;
      end else if (in_file(ra)) begin
        s_nxt.rdata[15:0] = s_r.file[ra[crf_pkg::FILE_BANK_BIT]][ra[4:crf_pkg::FILE_IDX_LSB]];
      end else begin
        s_nxt.rresp = crf_pkg::RESP_SLVERR;
      end
    end

    // Core write wins over a bus write in the same cycle
    if (wr_req.en) begin
      s_nxt.file[s_r.bank] = write_op(s_nxt.file[s_r.bank], wr_req.sel, wr_req.data);
    end

    // Ready flags from the next state
    s_nxt.awready = !s_nxt.aw_have && !s_nxt.bvalid;
    s_nxt.wready = !s_nxt.w_have && !s_nxt.bvalid;
    s_nxt.arready = !s_nxt.rvalid;
  end

  // ****************************************
  // State register
  // ****************************************
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_r <= '0;
      s_r.file <= {(crf_pkg::NUM_BANKS * crf_pkg::NUM_REGS){crf_pkg::REG_RESET}};
      s_r.awready <= 1'b1;
      s_r.wready <= 1'b1;
      s_r.arready <= 1'b1;
    end else begin
      s_r <= s_nxt;
    end
  end

  // Outputs straight from the state register
  assign rd_data = s_r.rd_data;
  assign rd_valid = s_r.rd_valid;
  assign bank_sel = s_r.bank;
  assign s_axi_awready = s_r.awready;
  assign s_axi_wready = s_r.wready;
  assign s_axi_bvalid = s_r.bvalid;
  assign s_axi_bresp = s_r.bresp;
  assign s_axi_arready = s_r.arready;
  assign s_axi_rvalid = s_r.rvalid;
  assign s_axi_rdata = s_r.rdata;
  assign s_axi_rresp = s_r.rresp;

  // ****************************************
  // Checks
  // ****************************************

  // Helper views
  logic [15:0] b0_d0;
  logic [15:0] b1_d0;
  logic [15:0] b0_d2;
  logic [15:0] b1_adr0;
  logic [15:0] b0_frm;
  logic [15:0] wr_lo;
  logic [7:0] wr_b;
  assign b0_d0 = s_r.file[0][crf_pkg::IDX_D0];
  assign b1_d0 = s_r.file[1][crf_pkg::IDX_D0];
  assign b0_d2 = s_r.file[0][crf_pkg::IDX_D2];
  assign b1_adr0 = s_r.file[1][crf_pkg::IDX_ADR0];
  assign b0_frm = s_r.file[0][crf_pkg::IDX_FRM];
  assign wr_lo = wr_req.data[15:0];
  assign wr_b = wr_req.data[7:0];

  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  // Core write to bank zero with no bus write held in both halves
  sequence core_wr0(crf_pkg::crf_sel_e sl);
    wr_req.en && (wr_req.sel == sl) && !s_r.bank && !(s_r.aw_have && s_r.w_have);
  endsequence

  // Bus write address and data taken together
  sequence axi_both_taken;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence

  bank_isolate_a: assert property (
    core_wr0(crf_pkg::CRF_SEL_D0) |=> (b1_d0 == $past(b1_d0)))
    else $error("bank one changed by bank zero write");

  word_write_a: assert property (
    core_wr0(crf_pkg::CRF_SEL_D0) |=> (b0_d0 == $past(wr_lo)))
    else $error("data word write lost");

  byte_keep_a: assert property (
    core_wr0(crf_pkg::CRF_SEL_D0_HI) |=>
      (b0_d0[7:0] == $past(b0_d0[7:0])) && (b0_d0[15:8] == $past(wr_b)))
    else $error("byte write disturbed other byte");

  pair_read_a: assert property (
    (rd_req.en && rd_req.sel == crf_pkg::CRF_SEL_PAIR_LOW_LONG && !s_r.bank) |=>
      rd_valid && (rd_data == {$past(b0_d2), $past(b0_d0)}))
    else $error("low long pair read wrong");

  addr_pair_a: assert property (
    (wr_req.en && wr_req.sel == crf_pkg::CRF_SEL_ADDR_PAIR_LONG && s_r.bank) |=>
      (b1_adr0 == $past(wr_lo)))
    else $error("address pair low half wrong");

  read_latency_a: assert property (
    rd_req.en |=> rd_valid ##1 (rd_valid == $past(rd_req.en)))
    else $error("operand read not answered in one cycle");

  frame_base_a: assert property (
    core_wr0(crf_pkg::CRF_SEL_FRM) |=> (b0_frm == $past(wr_lo)))
    else $error("frame base write lost");

  bank_route_a: assert property (
    (wr_req.en && wr_req.sel == crf_pkg::CRF_SEL_ADR0 && !s_r.bank) |=>
      $stable(b1_adr0) || $past(s_r.aw_have && s_r.w_have))
    else $error("write went to unselected bank");

  axi_write_a: assert property (
    axi_both_taken |=> ##1 s_axi_bvalid)
    else $error("write response late");

endmodule : crf_core_regfile

`default_nettype wire

/* crf_core_model.sv */
`timescale 1ns/1ps
`default_nettype none
// ****************************************
// Execution side model of the core
// ****************************************
module crf_core_model (
  // Clock
  input wire logic aclk,
  // Operand requests
  output var crf_pkg::crf_rd_req_s rd_req,
  output var crf_pkg::crf_wr_req_s wr_req
);
  // Idle requests from time zero
  initial begin
    rd_req = '0;
    wr_req = '0;
  end

  // One access held for one edge, data scrambled once released
  task automatic op(input logic w, input logic [3:0] s, input logic [31:0] d);
    @(posedge aclk);
    if (w) wr_req <= '{1'b1, crf_pkg::crf_sel_e'(s), d};
    else rd_req <= '{1'b1, crf_pkg::crf_sel_e'(s)};
    @(posedge aclk);
    wr_req <= '{1'b0, crf_pkg::crf_sel_e'(~s), ~d};
    rd_req.en <= 1'b0;
  endtask : op
endmodule : crf_core_model
`default_nettype wire

/* tb_top.sv */
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin n_checks++; if ((a) !== (b)) begin fail_count++; \
  $display("CHECK FAILED t=%0t got=%h exp=%h", $time, a, b); end end
// ****************************************
// Bench top
// ****************************************
module tb_top;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [7:0] awaddr = '0, araddr = '0;
  logic [31:0] wdata = '0, rd_data, rdata;
  logic [3:0] wstrb = '0;
  logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
  logic awready, wready, bvalid, arready, rvalid, rd_valid, bank_sel;
  logic [1:0] bresp, rresp, eb;
  logic [33:0] er;
  logic [31:0] ec;
  crf_pkg::crf_rd_req_s rd_req;
  crf_pkg::crf_wr_req_s wr_req;
  logic [15:0] m [2][7];
  logic bk = 1'b0;
  logic [31:0] cq[$];
  logic [33:0] rq[$];
  logic [1:0] bq[$];
  int fail_count = 0, n_checks = 0, cyc = 0, i, k;
  integer seed = 32'h46e7;

  // Clock, 40 ns period
  always #20 aclk = ~aclk;

  crf_core_model u_crf_core_model (.aclk(aclk), .rd_req(rd_req), .wr_req(wr_req));

  crf_core_regfile #(.ADDR_W(8)) u_crf_core_regfile (
    .aclk(aclk), .aresetn(aresetn), .rd_req(rd_req), .rd_data(rd_data),
    .rd_valid(rd_valid), .wr_req(wr_req), .bank_sel(bank_sel),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
    .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready));

  // ****************************************
  // Reference model
  // ****************************************
  function automatic logic [31:0] ref_rd(input logic [3:0] s);
    case (s)
      4'h7: ref_rd = {24'h0, m[bk][0][15:8]};
      4'h8: ref_rd = {24'h0, m[bk][0][7:0]};
      4'h9: ref_rd = {24'h0, m[bk][1][15:8]};
      4'ha: ref_rd = {24'h0, m[bk][1][7:0]};
      4'hb: ref_rd = {m[bk][2], m[bk][0]};
      4'hc: ref_rd = {m[bk][3], m[bk][1]};
      4'hd: ref_rd = {m[bk][5], m[bk][4]};
      default: ref_rd = (s < 4'h7) ? {16'h0, m[bk][s[2:0]]} : 32'h0;
    endcase
  endfunction : ref_rd

  task automatic ref_wr(input logic [3:0] s, input logic [31:0] d);
    case (s)
      4'h7: m[bk][0][15:8] = d[7:0];
      4'h8: m[bk][0][7:0] = d[7:0];
      4'h9: m[bk][1][15:8] = d[7:0];
      4'ha: m[bk][1][7:0] = d[7:0];
      4'hb: {m[bk][2], m[bk][0]} = d;
      4'hc: {m[bk][3], m[bk][1]} = d;
      4'hd: {m[bk][5], m[bk][4]} = d;
      default: if (s < 4'h7) m[bk][s[2:0]] = d[15:0];
    endcase
  endtask : ref_wr

  // Bus answer as {resp, data}
  function automatic logic [33:0] axi_ref(input logic [7:0] a);
    if (a == 8'h00 || a == 8'h04) axi_ref = {2'h0, 31'h0, bk};
    else if (a >= 8'h40 && a < 8'h80 && a[1:0] == 2'h0 && a[4:2] != 3'h7)
      axi_ref = {2'h0, 16'h0, m[a[5]][a[4:2]]};
    else axi_ref = {2'h2, 32'h0};
  endfunction : axi_ref

  // ****************************************
  // Drivers
  // ****************************************
  task automatic core_wr(input logic [3:0] s, input logic [31:0] d);
    ref_wr(s, d);
    u_crf_core_model.op(1'b1, s, d);
  endtask : core_wr

  task automatic core_rd(input logic [3:0] s);
    cq.push_back(ref_rd(s));
    u_crf_core_model.op(1'b0, s, 32'h0);
  endtask : core_rd

  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] st);
    logic [33:0] r;
    logic ad, wd;
    r = axi_ref(a);
    bq.push_back(r[33:32]);
    ad = 0;
    wd = 0;
    @(posedge aclk);
    awaddr <= a;
    awvalid <= 1;
    wdata <= d;
    wstrb <= st;
    wvalid <= 1;
    bready <= 1;
    while (!(ad && wd)) begin
      @(posedge aclk);
      if (!ad && awready === 1'b1) begin ad = 1; awvalid <= 0; awaddr <= ~a; end
      if (!wd && wready === 1'b1) begin wd = 1; wvalid <= 0; wdata <= ~d; end
    end
    while (bvalid !== 1'b1) @(posedge aclk);
    bready <= 0;
    if (r[33:32] == 2'h0 && a >= 8'h40) begin
      if (st[0]) m[a[5]][a[4:2]][7:0] = d[7:0];
      if (st[1]) m[a[5]][a[4:2]][15:8] = d[15:8];
    end
    if (a == 8'h00) bk = d[0];
  endtask : axi_wr

  task automatic axi_rd(input logic [7:0] a);
    rq.push_back(axi_ref(a));
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1;
    rready <= 1;
    do @(posedge aclk); while (arready !== 1'b1);
    arvalid <= 0;
    araddr <= ~a;
    do @(posedge aclk); while (rvalid !== 1'b1);
    rready <= 0;
  endtask : axi_rd

  // Result watcher, oldest note first
  always @(posedge aclk) begin
    if (rd_valid === 1'b1) begin ec = cq.pop_front(); `CHK(rd_data, ec) end
    if (rvalid === 1'b1 && rready === 1'b1) begin er = rq.pop_front(); `CHK({rresp, rdata}, er) end
    if (bvalid === 1'b1 && bready === 1'b1) begin eb = bq.pop_front(); `CHK(bresp, eb) end
  end

  task automatic close_out;
    // Every noted result must have been answered
    `CHK(cq.size() + rq.size() + bq.size(), 0)
    $display("checks %0d mismatches %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : close_out

  // Hang guard
  always @(posedge aclk) begin
    cyc++;
    if (cyc == 8000) begin fail_count++; close_out(); end
  end

  // ****************************************
  // Main sequence
  // ****************************************
  initial begin
    foreach (m[b, r]) m[b][r] = 16'h0;
    repeat (16) @(posedge aclk);
    aresetn <= 1'b1;
    // Reset values of both banks and the empty slots
    for (i = 0; i < 16; i++) axi_rd(8'h40 + 8'(i * 4));
    $display("test reset values done");
    // Every selector written then read, in both banks
    for (k = 0; k < 2; k++) begin
      axi_wr(8'h00, 32'(k), 4'hf);
      `CHK(bank_sel, 1'(k))
      for (i = 0; i < 16; i++) core_wr(4'(i), $random(seed));
      for (i = 0; i < 16; i++) core_rd(4'(i));
      for (i = 15; i >= 0; i--) core_wr(4'(i), $random(seed));
      for (i = 0; i < 16; i++) core_rd(4'(i));
    end
    $display("test core access done");
    // Both banks kept apart, seen over the bus
    for (i = 0; i < 16; i++) axi_rd(8'h40 + 8'(i * 4));
    axi_rd(8'h04);
    $display("test bank copies done");
    // Byte strobes, read-only status, refused addresses
    axi_wr(8'h44, $random(seed), 4'h1);
    axi_wr(8'h64, $random(seed), 4'h2);
    axi_wr(8'h58, $random(seed), 4'h3);
    axi_wr(8'h04, 32'h0, 4'hf);
    axi_wr(8'h5c, $random(seed), 4'hf);
    axi_wr(8'h41, $random(seed), 4'hf);
    axi_rd(8'h90);
    axi_rd(8'h42);
    axi_rd(8'h04);
    axi_wr(8'h00, 32'h0, 4'hf);
    `CHK(bank_sel, 1'b0)
    for (i = 0; i < 16; i++) core_rd(4'(i));
    axi_wr(8'h00, 32'h1, 4'hf);
    for (i = 0; i < 16; i++) core_rd(4'(i));
    repeat (4) @(posedge aclk);
    $display("test bus access done");
    close_out();
  end
endmodule : tb_top
`default_nettype wire
